/* File: logic/psb_sram.sv */
// top of the pipelined single-cycle-deselect burst sram access logic
`timescale 1ns/1ps
//
// Behaviour
// - strap low selects linear burst order
// - strap high or open selects interleaved order
// - synchronous inputs and read data registered on rise
// - two-bit counter loads low address bits
// - only burst advance moves burst address
// - global write writes all four lanes
// - read: strobe low, selected, writes high
// - start stores address in register and counter
// - read data one rise after address registered
// - tristate first cycle leaving deselect
// - back-to-back reads without idle cycles
// - deselect tristates outputs one rise later
// - processor start ignores writes and advance
// - processor write completes at second rise
// - byte write touches only selected lanes
// - write cycle forces drivers off
// - controller write needs selects and write controls
// - controller write takes data with address
// - controller start ignores burst advance
// - both strobes low: processor strobe wins
// - processor strobe ignored with chip enable a high
// - advance low steps burst address
// - interleaved order xors start with count
module psb_sram #(
  parameter int ADDR_W = psb_pkg::ADDR_W,
  parameter int LANES = psb_pkg::LANES,
  parameter int LANE_W = psb_pkg::LANE_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MODE,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_ENABLE_N,
  input wire logic [LANES-1:0] BYTE_LANE_SELECT_N,
  input wire logic CHIP_ENABLE_A_N,
  input wire logic CHIP_ENABLE_B,
  input wire logic CHIP_ENABLE_C_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [LANES*LANE_W-1:0] DQ_IN,
  output logic [LANES*LANE_W-1:0] DQ_OUT,
  output logic DQ_OE
);

  localparam int BW = psb_pkg::BURST_W;
  localparam int DW = LANES * LANE_W;

  // ==========================================================
  // input registers
  psb_pkg::psb_ctl_t ctl_ff;
  psb_pkg::psb_ctl_t nxt_ctl;
  logic [ADDR_W-1:0] addr_ff;
  logic [DW-1:0] din_ff;
  logic mode_s1_ff;
  logic mode_s2_ff;

  assign nxt_ctl = '{
    processor_addr_strobe_n_n: PROCESSOR_ADDR_STROBE_N,
    controller_addr_strobe_n_n: CONTROLLER_ADDR_STROBE_N,
    adv_n: BURST_ADVANCE_N,
    gw_n: GLOBAL_WRITE_N,
    bwe_n: BYTE_WRITE_ENABLE_N,
    bw_n: BYTE_LANE_SELECT_N,
    ce_a_n: CHIP_ENABLE_A_N,
    ce_b: CHIP_ENABLE_B,
    ce_c_n: CHIP_ENABLE_C_N};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_ff <= psb_pkg::CTL_RST;
      addr_ff <= psb_pkg::ADDR_RST;
      din_ff <= psb_pkg::DATA_RST;
    end else begin
      ctl_ff <= nxt_ctl;
      addr_ff <= ADDR;
      din_ff <= DQ_IN;
    end
  end

  // strap is static, synchronised once into the clock domain
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_s1_ff <= psb_pkg::MODE_RST;
      mode_s2_ff <= psb_pkg::MODE_RST;
    end else begin
      mode_s1_ff <= MODE;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  // ==========================================================
  // cycle decode from the registered inputs
  logic [LANES-1:0] lanes;
  logic chip_on;
  logic p_start;
  logic c_start;
  logic start;
  logic sel_start;
  logic desel;
  logic in_burst;
  logic wr_req;
  logic wr_now;
  logic rd_now;
  logic step;
  psb_pkg::psb_sel_t state_ff;
  psb_pkg::psb_sel_t nxt_state;

  // lanes written by the write controls of this cycle
  function automatic logic [LANES-1:0] lane_mask(input logic gw_n,
                                                 input logic bwe_n,
                                                 input logic [LANES-1:0] bw_n);
    if (!gw_n) begin
      lane_mask = psb_pkg::LANES_ALL;
    end else if (!bwe_n) begin
      lane_mask = ~bw_n;
    end else begin
      lane_mask = psb_pkg::LANES_NONE;
    end
  endfunction

  assign lanes = lane_mask(ctl_ff.gw_n, ctl_ff.bwe_n, ctl_ff.bw_n);
  assign chip_on = ~ctl_ff.ce_a_n & ctl_ff.ce_b & ~ctl_ff.ce_c_n;
  assign p_start = ~ctl_ff.processor_addr_strobe_n_n & ~ctl_ff.ce_a_n;
  assign c_start = ~p_start & ~ctl_ff.controller_addr_strobe_n_n;
  assign start = p_start | c_start;
  assign sel_start = start & chip_on;
  assign desel = start & ~chip_on;
  assign in_burst = ~start & (state_ff == psb_pkg::PSB_SEL);
  assign wr_req = |lanes;
  // processor start never writes; its write follows on the next rise
  assign wr_now = wr_req & ((c_start & chip_on) | in_burst);
  assign rd_now = (sel_start & (p_start | ~wr_req)) | (in_burst & ~wr_req);
  // starts ignore advance; only a continue cycle may step
  assign step = in_burst & ~ctl_ff.adv_n;

  // ==========================================================
  // selection state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      psb_pkg::PSB_DESEL: begin
        if (sel_start) begin
          nxt_state = psb_pkg::PSB_SEL;
        end
      end
      psb_pkg::PSB_SEL: begin
        if (desel) begin
          nxt_state = psb_pkg::PSB_DESEL;
        end
      end
      default: begin
        nxt_state = psb_pkg::PSB_DESEL;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= psb_pkg::PSB_DESEL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // address path
  logic [ADDR_W-1:0] hi_ff;
  logic [ADDR_W-1:0] cur_addr;
  logic [BW-1:0] cur_low;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hi_ff <= psb_pkg::ADDR_RST;
    end else if (sel_start) begin
      hi_ff <= addr_ff;
    end
  end

  psb_burst #(.BW(BW)) u_burst (
    .clk(CLK),
    .rst(RST),
    .load(sel_start),
    .step(step),
    .interleave(mode_s2_ff),
    .load_val(addr_ff[BW-1:0]),
    .cur(cur_low)
  );

  // started address goes straight to the array in its own cycle
  assign cur_addr = sel_start ? addr_ff : {hi_ff[ADDR_W-1:BW], cur_low};

  // ==========================================================
  // array and output register
  psb_mem #(.AW(ADDR_W), .LANES(LANES), .LW(LANE_W)) u_mem (
    .clk(CLK),
    .rst(RST),
    .wr_en(wr_now),
    .lane_en(lanes),
    .rd_en(rd_now),
    .addr(cur_addr),
    .wdata(din_ff),
    .rdata_ff(DQ_OUT)
  );

  // ==========================================================
  // output driver control
  logic drv_ff;

  // drivers follow the read one rise later, which also gives the
  // first-cycle tristate and the extra cycle on deselect
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      drv_ff <= 1'h0;
    end else begin
      drv_ff <= rd_now;
    end
  end

  // output enable is not sampled; a write cycle overrides it
  assign DQ_OE = drv_ff & ~wr_now & ~OUTPUT_ENABLE_N;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_desel_busy;
    desel && drv_ff;
  endsequence

  sequence s_adv4;
    (in_burst && !ctl_ff.adv_n) [*4];
  endsequence

  sequence s_ctl_read;
    c_start && chip_on && !wr_req;
  endsequence

  property p_desel_late;
    s_desel_busy |-> drv_ff ##1 !drv_ff;
  endproperty
  a_desel_late: assert property (p_desel_late)
    else $error("deselect did not tristate one rise later");

  property p_write_off;
    wr_now |-> !DQ_OE;
  endproperty
  a_write_off: assert property (p_write_off)
    else $error("drivers on during write cycle");

  property p_oe_gate;
    (drv_ff && !wr_now && !OUTPUT_ENABLE_N) |-> DQ_OE;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("output enable did not turn drivers on");

  property p_ctl_read;
    s_ctl_read |=> drv_ff && DQ_OUT == $past(u_mem.mem[cur_addr]);
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("controller read data missing one rise later");

  property p_first_off;
    (state_ff == psb_pkg::PSB_DESEL && sel_start) |-> !DQ_OE;
  endproperty
  a_first_off: assert property (p_first_off)
    else $error("drivers on in first cycle after deselect");

  property p_proc_nowrite;
    (p_start && chip_on) |-> !wr_now && cur_addr == addr_ff;
  endproperty
  a_proc_nowrite: assert property (p_proc_nowrite)
    else $error("processor start wrote or used wrong address");

  property p_proc_wins;
    (!ctl_ff.processor_addr_strobe_n_n && !ctl_ff.controller_addr_strobe_n_n && !ctl_ff.ce_a_n) |-> !c_start;
  endproperty
  a_proc_wins: assert property (p_proc_wins)
    else $error("controller strobe acted beside processor strobe");

  property p_ce_gate;
    ctl_ff.ce_a_n |-> !p_start;
  endproperty
  a_ce_gate: assert property (p_ce_gate)
    else $error("processor strobe acted with chip enable a high");

  property p_hold;
    (in_burst && ctl_ff.adv_n) |-> cur_low == $past(cur_low);
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst address moved without advance");

  property p_step;
    (in_burst && !ctl_ff.adv_n) |-> cur_low != $past(cur_low);
  endproperty
  a_step: assert property (p_step)
    else $error("burst address did not step");

  property p_wrap;
    s_adv4 |-> cur_low == $past(cur_low, 4);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst did not wrap after four");

  property p_linear;
    (in_burst && !ctl_ff.adv_n && !mode_s2_ff) |-> cur_low == BW'($past(cur_low) + 2'h1);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear order step wrong");

  property p_gw_all;
    (wr_now && !ctl_ff.gw_n) |-> lanes == psb_pkg::LANES_ALL;
  endproperty
  a_gw_all: assert property (p_gw_all)
    else $error("global write missed a lane");

endmodule

/* File: logic/psb_pkg.sv */
// shared constants and types of the pipelined burst sram access block
package psb_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;

  // ==========================================================
  // values after reset, lane masks and burst step
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic MODE_RST = 1'h1;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

  // ==========================================================
  // selection state
  typedef enum logic [1:0] {
    PSB_DESEL = 2'b01,
    PSB_SEL = 2'b10
  } psb_sel_t;

  // ==========================================================
  // synchronous control inputs, all active low except ce_b
  typedef struct packed {
    logic processor_addr_strobe_n_n;
    logic controller_addr_strobe_n_n;
    logic adv_n;
    logic gw_n;
    logic bwe_n;
    logic [LANES-1:0] bw_n;
    logic ce_a_n;
    logic ce_b;
    logic ce_c_n;
  } psb_ctl_t;

  localparam psb_ctl_t CTL_RST = '{
    processor_addr_strobe_n_n: 1'h1, controller_addr_strobe_n_n: 1'h1, adv_n: 1'h1, gw_n: 1'h1, bwe_n: 1'h1,
    bw_n: 4'hF, ce_a_n: 1'h1, ce_b: 1'h0, ce_c_n: 1'h1};

endpackage

/* File: logic/psb_mem.sv */
// memory array with byte lane writes and registered read data
`timescale 1ns/1ps
module psb_mem #(
  parameter int AW = psb_pkg::ADDR_W,
  parameter int LANES = psb_pkg::LANES,
  parameter int LW = psb_pkg::LANE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [LANES-1:0] lane_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [LANES*LW-1:0] wdata,
  output logic [LANES*LW-1:0] rdata_ff
);

  logic [LANES*LW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // array write, unselected lanes keep their contents
  always_ff @(posedge clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_en && lane_en[i]) begin
        mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
      end
    end
  end

  // ==========================================================
  // output register, holds between reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (rd_en) begin
      rdata_ff <= mem[addr];
    end
  end

endmodule

/* File: logic/psb_burst.sv */
// two-bit wraparound burst counter, linear or interleaved order
`timescale 1ns/1ps
module psb_burst #(
  parameter int BW = psb_pkg::BURST_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic step,
  input wire logic interleave,
  input wire logic [BW-1:0] load_val,
  output logic [BW-1:0] cur
);

  logic [BW-1:0] base_ff;
  logic [BW-1:0] cnt_ff;
  logic [BW-1:0] nxt_cnt;

  // position of count within the burst for the chosen order
  function automatic logic [BW-1:0] order(input logic [BW-1:0] b,
                                          input logic [BW-1:0] c,
                                          input logic il);
    order = il ? (b ^ c) : BW'(b + c);
  endfunction

  // ==========================================================
  // count selection
  assign nxt_cnt = load ? psb_pkg::BURST_RST :
                   step ? BW'(cnt_ff + psb_pkg::BURST_ONE) : cnt_ff;
  assign cur = load ? load_val : order(base_ff, nxt_cnt, interleave);

  // ==========================================================
  // counter state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_ff <= psb_pkg::BURST_RST;
      cnt_ff <= psb_pkg::BURST_RST;
    end else begin
      if (load) begin
        base_ff <= load_val;
      end
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

/* File: test/psb_ctl_model.sv */
// bus controller model driving the synchronous inputs of the burst sram block
`timescale 1ns/1ps
module psb_ctl_model (
  input wire logic clk,
  output psb_pkg::psb_ctl_t ctl,
  output logic [19:0] addr,
  output logic oe_n,
  output logic [35:0] dq
);
  logic rude;

  initial begin
    ctl = psb_pkg::CTL_RST;
    addr = 20'h00000;
    oe_n = 1'h0;
    dq = 36'h000000000;
    rude = 1'h0;
  end

  // ==========================================================
  // one bus cycle: set at a falling edge, held to the next one
  task automatic drive(input logic p, input logic s, input logic v, input logic g,
                       input logic b, input logic [3:0] bw, input logic e,
                       input logic [19:0] a, input logic [35:0] d);
    logic wr;
    wr = !g || (!b && bw != 4'hF);
    ctl = '{processor_addr_strobe_n_n: p, controller_addr_strobe_n_n: s, adv_n: v, gw_n: g, bwe_n: b, bw_n: bw,
            ce_a_n: !e, ce_b: e, ce_c_n: !e};
    addr = a;
    oe_n = wr && !rude;
    dq = wr ? d : ~dq;
    @(negedge clk);
  endtask
endmodule

/* File: test/psb_sram_test.sv */
// self-checking bench of the pipelined burst sram access block
`timescale 1ns/1ps
module psb_sram_test;
  logic clk;
  logic rst;
  logic mode;
  psb_pkg::psb_ctl_t ctl;
  logic [19:0] addr;
  logic oe_n;
  logic [35:0] dq;
  logic [35:0] dq_out;
  logic dq_oe;
  logic [31:0] seed = 32'h0000000A;
  logic [35:0] mem [4];
  logic [35:0] d;
  logic [19:0] base;
  logic [3:0] ln;
  logic [1:0] s;
  logic [1:0] pr;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  psb_ctl_model u_ctl (.clk(clk), .ctl(ctl), .addr(addr), .oe_n(oe_n), .dq(dq));

  psb_sram dut (
    .CLK(clk), .RST(rst), .MODE(mode), .ADDR(addr),
    .PROCESSOR_ADDR_STROBE_N(ctl.processor_addr_strobe_n_n), .CONTROLLER_ADDR_STROBE_N(ctl.controller_addr_strobe_n_n),
    .BURST_ADVANCE_N(ctl.adv_n), .GLOBAL_WRITE_N(ctl.gw_n),
    .BYTE_WRITE_ENABLE_N(ctl.bwe_n), .BYTE_LANE_SELECT_N(ctl.bw_n),
    .CHIP_ENABLE_A_N(ctl.ce_a_n), .CHIP_ENABLE_B(ctl.ce_b), .CHIP_ENABLE_C_N(ctl.ce_c_n),
    .OUTPUT_ENABLE_N(oe_n), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // expectation helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [35:0] rnd36();
    logic [31:0] h;
    h = rnd();
    return {h[3:0], rnd()};
  endfunction

  function automatic logic [1:0] ba(input logic [1:0] st, input logic [1:0] c);
    return mode ? (st ^ c) : (st + c);
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] l);
    logic [35:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (l[k]) r[k*9+:9] = n[k*9+:9];
    end
    return r;
  endfunction

  // ==========================================================
  // compares and closing
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1500) begin
      err_total++;
      stop_test();
    end
  end

  // ==========================================================
  // bus cycle shorthands; advance low on starts must be ignored
  task automatic start(input logic p, input logic c, input logic [19:0] a, input logic g);
    u_ctl.drive(p, c, 1'h0, g, 1'h1, 4'hF, 1'h1, a, rnd36());
  endtask

  task automatic cont(input logic v, input logic b, input logic [3:0] bw,
                      input logic [35:0] wd);
    u_ctl.drive(1'h1, 1'h1, v, 1'h1, b, bw, 1'h1, 20'(rnd()), wd);
  endtask

  initial begin
    rst = 1'h1;
    mode = 1'h0;
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      rst = 1'h1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      repeat (3) cont(1'h1, 1'h1, 4'hF, 36'h0);
      base = 20'(rnd()) & 20'hFFFFC;
      for (int i = 0; i < 4; i++) begin
        mem[i] = rnd36();
        u_ctl.rude = (i == 2);
        u_ctl.drive(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 4'hF, 1'h1, base | 20'(i), mem[i]);
        chk_bit(dq_oe, 1'h0);
      end
      u_ctl.rude = 1'h0;
      s = 2'(rnd());
      start(1'h0, 1'h1, {base[19:2], s}, 1'h0);
      for (int i = 0; i < 6; i++) begin
        cont(i < 4 ? 1'h0 : 1'h1, 1'h1, 4'hF, 36'h0);
        chk_data(dq_out, mem[ba(s, i < 4 ? i[1:0] : 2'h0)]);
      end
      chk_bit(dq_oe, 1'h1);
      u_ctl.oe_n = 1'h1;
      #1 chk_bit(dq_oe, 1'h0);
      u_ctl.oe_n = 1'h0;
      #1 chk_bit(dq_oe, 1'h1);
      @(negedge clk);
      ln = 4'(rnd());
      d = rnd36();
      start(1'h0, 1'h1, {base[19:2], s}, 1'h0);
      cont(1'h1, 1'h0, ~ln, d);
      chk_bit(dq_oe, ln == 4'h0);
      mem[s] = merge(mem[s], d, ln);
      start(1'h1, 1'h0, {base[19:2], s}, 1'h1);
      cont(1'h1, 1'h1, 4'hF, 36'h0);
      chk_data(dq_out, mem[s]);
      start(1'h0, 1'h0, {base[19:2], s}, 1'h0);
      cont(1'h1, 1'h1, 4'hF, 36'h0);
      chk_data(dq_out, mem[s]);
      cont(1'h1, 1'h1, 4'hF, 36'h0);
      chk_data(dq_out, mem[s]);
      u_ctl.drive(1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, 1'h0, base, rnd36());
      chk_bit(dq_oe, 1'h1);
      cont(1'h1, 1'h1, 4'hF, 36'h0);
      chk_bit(dq_oe, 1'h0);
      for (int i = 0; i < 9; i++) begin
        s = 2'(rnd());
        start(1'h1, 1'h0, {base[19:2], s}, 1'h1);
        if (i == 0) chk_bit(dq_oe, 1'h0);
        if (i > 0) chk_data(dq_out, mem[pr]);
        pr = s;
      end
      $display("mode %0d tests done", m);
    end
    stop_test();
  end
endmodule
